//--- hw/twbm_master.sv
// twbm_master: two-wire bus master with register port and dma requests
// assumes pins resolved open drain outside; pin_select from the pin mux
`timescale 1ns/10ps
module twbm_master (
  input wire logic clk,
  input wire logic rst_n,
  input wire twbm_pkg::twbm_addr_type reg_addr,
  input wire twbm_pkg::twbm_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output twbm_pkg::twbm_byte_type reg_rdata,
  input wire logic pin_select,
  input wire logic scl_pin,
  output logic scl_low,
  output logic scl_oe_n,
  input wire logic sda_pin,
  output logic sda_low,
  output logic sda_oe_n,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  import twbm_pkg::*;
  // ==========================================================
  // state
  twbm_ctl_type ctl_reg; // software control
  twbm_ctl_type ctl_w; // incoming control write
  twbm_byte_type hold_reg; // transmit data register
  twbm_byte_type rx_data_reg; // last received byte
  twbm_byte_type brg_hi_reg, brg_lo_reg, rdata_reg;
  logic [15:0] baud_cnt_reg;
  twbm_pins_type pin_meta_reg, pin_sync_reg;
  twbm_state_type state_reg, state_next;
  logic [1:0] phase_reg; // quarter of the current bus bit
  logic [2:0] bit_reg;
  twbm_byte_type shift_reg;
  logic rx_mode_reg, addr_byte_reg, read_dir_reg;
  logic nak_pend_reg, ack_reg, scl_pull_reg, sda_pull_reg;
  logic dr_full_reg, transmit_empty_flag_reg, receive_full_flag_reg, not_acknowledged_flag_reg, baud_flag_reg, en_d_reg;
  twbm_st_type st_w;
  twbm_byte_type rd_mux;
  // ==========================================================
  // register decode
  wire logic wr_data = reg_wr & (reg_addr == TWBM_ADDR_DATA);
  wire logic wr_ctl = reg_wr & (reg_addr == TWBM_ADDR_CTL);
  wire logic wr_brh = reg_wr & (reg_addr == TWBM_ADDR_BRH);
  wire logic wr_brl = reg_wr & (reg_addr == TWBM_ADDR_BRL);
  wire logic rd_data = reg_rd & (reg_addr == TWBM_ADDR_DATA);
  wire logic rd_st = reg_rd & (reg_addr == TWBM_ADDR_STAT);
  assign ctl_w = twbm_ctl_type'(reg_wdata);
  wire logic flush_ev = wr_ctl & ctl_w.flush;
  wire logic en_rise = ctl_reg.en & ~en_d_reg;
  // ==========================================================
  // baud generator; bus use clamps the divider for the rate ceiling
  wire logic [15:0] brg_w = {brg_hi_reg, brg_lo_reg};
  wire logic slow_clamp = ctl_reg.en & (brg_w < TWBM_MIN_RELOAD);
  wire logic [15:0] reload_w = slow_clamp ? TWBM_MIN_RELOAD : brg_w;
  wire logic tick = (baud_cnt_reg <= TWBM_CNT_ONE);
  wire logic baud_ev = tick & ~ctl_reg.en & ctl_reg.baud_timer_irq_request;
  // count down to one, then reload; a divider write restarts the count so that
  // software need not sit out the long countdown left over from reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      baud_cnt_reg <= {TWBM_BRG_RESET, TWBM_BRG_RESET};
    end else if (tick | wr_brh | wr_brl) begin
      baud_cnt_reg <= reload_w;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - TWBM_CNT_ONE;
    end
  end
  // ==========================================================
  // pin synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= TWBM_PINS_IDLE;
      pin_sync_reg <= TWBM_PINS_IDLE;
    end else begin
      pin_meta_reg <= {scl_pin, sda_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // ==========================================================
  // sequencer decode
  wire logic is_idle = (state_reg == TWBM_IDLE);
  wire logic in_start = (state_reg == TWBM_COND_START);
  wire logic in_bits = (state_reg == TWBM_BITS);
  wire logic in_ack = (state_reg == TWBM_ACK);
  wire logic in_post = (state_reg == TWBM_POST);
  wire logic in_stop = (state_reg == TWBM_COND_STOP);
  wire logic ph_first = (phase_reg == TWBM_PH_FIRST);
  wire logic ph_samp = (phase_reg == TWBM_PH_SAMPLE);
  wire logic ph_last = (phase_reg == TWBM_PH_LAST);
  // scl released but still low: a slave is stretching the clock
  wire logic scl_wait = ~scl_pull_reg & ~pin_sync_reg.scl & ~is_idle;
  wire logic step = ctl_reg.en & tick & ~scl_wait;
  // no pending data and no start/stop: this byte is not the last one
  wire logic tx_stall = ~rx_mode_reg & transmit_empty_flag_reg & ~ctl_reg.start & ~ctl_reg.stop;
  wire logic hold_ack = in_ack & ph_first & tx_stall;
  wire logic adv = step & ~hold_ack;
  wire logic byte_end = in_bits & adv & ph_last & (bit_reg == TWBM_BIT_LAST);
  wire logic ack_end = in_ack & adv & ph_last;
  wire logic start_done = in_start & adv & ph_last;
  wire logic stop_done = in_stop & adv & ph_last;
  wire logic go_start = ctl_reg.start & dr_full_reg;
  wire logic idle_go = is_idle & step & go_start;
  wire logic post_stop = in_post & step & ctl_reg.stop;
  wire logic post_start = in_post & step & ~ctl_reg.stop & go_start;
  // a nak freezes the bus until software sets start or stop
  wire logic post_free = in_post & step & ~ctl_reg.stop & ~go_start & ~nak_pend_reg;
  wire logic post_rx = post_free & rx_mode_reg & ~receive_full_flag_reg;
  wire logic post_tx = post_free & ~rx_mode_reg & dr_full_reg;
  wire logic load_ev = start_done | post_tx;
  wire logic load_read = start_done & hold_reg[TWBM_RW_BIT];
  wire logic rx_done = byte_end & rx_mode_reg;
  wire logic not_acknowledged_flag_set = ack_end & nak_pend_reg & ~ctl_reg.start & ~ctl_reg.stop;
  wire logic transmit_empty_flag_set = en_rise | (load_ev & ~load_read);
  // ==========================================================
  // sequencer: one master owns the bus, no arbitration
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TWBM_IDLE: if (idle_go) state_next = TWBM_COND_START;
      TWBM_COND_START: if (start_done) state_next = TWBM_BITS;
      TWBM_BITS: if (byte_end) state_next = TWBM_ACK;
      TWBM_ACK: if (ack_end) state_next = TWBM_POST;
      TWBM_POST: begin
        if (post_stop) begin
          state_next = TWBM_COND_STOP;
        end else if (post_start) begin
          state_next = TWBM_COND_START;
        end else if (post_rx | post_tx) begin
          state_next = TWBM_BITS;
        end
      end
      TWBM_COND_STOP: if (stop_done) state_next = TWBM_IDLE;
      default: state_next = TWBM_IDLE;
    endcase
  end
  // state and quarter counter; disabling drops the bus at once
  always_ff @(posedge clk) begin
    if (!rst_n || !ctl_reg.en) begin
      state_reg <= TWBM_IDLE;
      phase_reg <= TWBM_PH_FIRST;
    end else begin
      state_reg <= state_next;
      if (adv & ~in_post & ~is_idle) phase_reg <= phase_reg + TWBM_PH_CHANGE;
    end
  end
  // ==========================================================
  // shifter and byte bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bit_reg <= '0;
      rx_mode_reg <= 1'b0;
      addr_byte_reg <= 1'b0;
      read_dir_reg <= 1'b0;
      nak_pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      // 10-bit second address bytes and data both travel as write bytes
      if (load_ev) begin
        shift_reg <= hold_reg;
        bit_reg <= '0;
      end else if (in_bits & adv & ph_samp) begin
        shift_reg <= {shift_reg[6:0], pin_sync_reg.sda};
      end
      if (in_bits & adv & ph_last) bit_reg <= bit_reg + 3'h1;
      if (start_done) begin
        addr_byte_reg <= 1'b1;
        read_dir_reg <= hold_reg[TWBM_RW_BIT];
        rx_mode_reg <= 1'b0;
        nak_pend_reg <= 1'b0;
      end else if (ack_end) begin
        rx_mode_reg <= rx_mode_reg | (addr_byte_reg & read_dir_reg);
        addr_byte_reg <= 1'b0;
      end else if (stop_done) begin
        rx_mode_reg <= 1'b0;
      end
      // acknowledge sampled mid-high; on reads our own answer counts
      if (in_ack & adv & ph_samp) begin
        if (rx_mode_reg) begin
          nak_pend_reg <= ctl_reg.nak;
        end else begin
          nak_pend_reg <= pin_sync_reg.sda;
          ack_reg <= ~pin_sync_reg.sda;
        end
      end
    end
  end
  // ==========================================================
  // pin drive; sda moves only mid-low except in conditions
  wire logic upd_sda = (phase_reg == TWBM_PH_CHANGE) | ((in_start | in_stop) & ph_last);
  wire logic sda_val = in_start ? ph_last :
                       in_stop ? ~ph_last :
                       in_bits ? (~rx_mode_reg & ~shift_reg[7]) :
                       in_ack ? (rx_mode_reg & ~ctl_reg.nak) : 1'b0;
  wire logic scl_val = ~is_idle & (in_post | (phase_reg < TWBM_PH_SAMPLE));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_pull_reg <= 1'b0;
      sda_pull_reg <= 1'b0;
    end else begin
      scl_pull_reg <= scl_val;
      if (is_idle) begin
        sda_pull_reg <= 1'b0;
      end else if (upd_sda) begin
        sda_pull_reg <= sda_val;
      end
    end
  end
  // open drain: level always low, enable only when selected
  assign scl_low = 1'b0;
  assign sda_low = 1'b0;
  assign scl_oe_n = ~(pin_select & scl_pull_reg);
  assign sda_oe_n = ~(pin_select & sda_pull_reg);
  // ==========================================================
  // software registers; hardware clears start/stop when sent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg <= '0;
      brg_hi_reg <= TWBM_BRG_RESET;
      brg_lo_reg <= TWBM_BRG_RESET;
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= ctl_reg.en;
      if (wr_ctl) begin
        ctl_reg <= ctl_w;
        ctl_reg.flush <= 1'b0;
        ctl_reg.rsvd <= 1'b0;
      end else begin
        if (start_done) ctl_reg.start <= 1'b0;
        if (stop_done) ctl_reg.stop <= 1'b0;
      end
      if (wr_brh) brg_hi_reg <= reg_wdata;
      if (wr_brl) brg_lo_reg <= reg_wdata;
    end
  end
  // data register and status flags; sets win over clears, except a data write clears transmit empty over its set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_reg <= '0;
      dr_full_reg <= 1'b0;
      transmit_empty_flag_reg <= 1'b0;
      receive_full_flag_reg <= 1'b0;
      not_acknowledged_flag_reg <= 1'b0;
      baud_flag_reg <= 1'b0;
      rx_data_reg <= '0;
    end else begin
      if (wr_data) hold_reg <= reg_wdata;
      if (wr_data) begin
        dr_full_reg <= 1'b1;
      end else if (load_ev | flush_ev) begin
        dr_full_reg <= 1'b0;
      end
      // a write in the load cycle keeps the register full, so no set
      if (wr_data) begin
        transmit_empty_flag_reg <= 1'b0;
      end else if (transmit_empty_flag_set) begin
        transmit_empty_flag_reg <= 1'b1;
      end
      if (rx_done) rx_data_reg <= shift_reg;
      if (rx_done) begin
        receive_full_flag_reg <= 1'b1;
      end else if (rd_data) begin
        receive_full_flag_reg <= 1'b0;
      end
      if (not_acknowledged_flag_set) begin
        not_acknowledged_flag_reg <= 1'b1;
      end else if (wr_ctl & (ctl_w.start | ctl_w.stop)) begin
        not_acknowledged_flag_reg <= 1'b0;
      end
      if (baud_ev) begin
        baud_flag_reg <= 1'b1;
      end else if (rd_st) begin
        baud_flag_reg <= 1'b0;
      end
    end
  end
  // ==========================================================
  // interrupt and dma requests
  assign irq = (ctl_reg.en & ctl_reg.transmit_irq_enable & transmit_empty_flag_reg) | (ctl_reg.en & receive_full_flag_reg)
             | (ctl_reg.en & not_acknowledged_flag_reg)
             | (ctl_reg.baud_timer_irq_request & ~ctl_reg.en & baud_flag_reg);
  assign tx_dma_req = ctl_reg.en & ctl_reg.transmit_irq_enable & transmit_empty_flag_reg;
  assign rx_dma_req = ctl_reg.en & receive_full_flag_reg;
  // ==========================================================
  // read path; data stand for one cycle only
  assign st_w = '{transmit_empty_flag: transmit_empty_flag_reg, receive_full_flag: receive_full_flag_reg, ack: ack_reg, rd: read_dir_reg,
                  baud: baud_flag_reg, busy: ~is_idle, not_acknowledged_flag: not_acknowledged_flag_reg, rsvd: 1'b0};
  assign rd_mux = (reg_addr == TWBM_ADDR_DATA) ? rx_data_reg :
                  (reg_addr == TWBM_ADDR_STAT) ? st_w :
                  (reg_addr == TWBM_ADDR_CTL) ? ctl_reg :
                  (reg_addr == TWBM_ADDR_BRH) ? brg_hi_reg :
                  (reg_addr == TWBM_ADDR_BRL) ? brg_lo_reg : '0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_reg;
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence tx_load_s;
    load_ev && !wr_data && !load_read;
  endsequence
  sequence ack_wait_s;
    in_ack && ph_first && tx_stall && ctl_reg.en;
  endsequence
  sequence idle_exit_s;
    is_idle ##1 in_start;
  endsequence
  transmit_empty_flag_load_a: assert property (tx_load_s |=> transmit_empty_flag_reg)
    else $error("transmit empty not set on load");
  wr_clr_transmit_empty_flag_a: assert property (wr_data |=> !transmit_empty_flag_reg)
    else $error("data write left transmit empty set");
  ack_stall_a: assert property (ack_wait_s |=> in_ack && ph_first && scl_pull_reg)
    else $error("ack phase left while transmit empty");
  scl_stretch_a: assert property ((scl_wait && ctl_reg.en) |=> $stable(phase_reg))
    else $error("phase moved while scl held low");
  start_cond_a: assert property (($rose(sda_pull_reg) && in_start) |-> !scl_pull_reg)
    else $error("start edge without scl high");
  stop_cond_a: assert property (($fell(sda_pull_reg) && in_stop) |-> !scl_pull_reg)
    else $error("stop edge without scl high");
  sda_mid_low_a: assert property (($changed(sda_pull_reg) && (in_bits || in_ack))
    |-> scl_pull_reg)
    else $error("sda moved while scl high");
  receive_full_flag_set_a: assert property (rx_done |=> receive_full_flag_reg)
    else $error("receive full not set");
  rx_pause_a: assert property ((in_post && rx_mode_reg && receive_full_flag_reg) |=> !in_bits)
    else $error("next byte read before data read");
  not_acknowledged_flag_set_a: assert property (not_acknowledged_flag_set |=> not_acknowledged_flag_reg)
    else $error("nak flag not set");
  nak_hold_a: assert property ((in_post && nak_pend_reg && ctl_reg.en && !ctl_reg.start
    && !ctl_reg.stop) |=> in_post)
    else $error("bus moved after nak");
  start_gate_a: assert property (idle_exit_s |-> $past(dr_full_reg) && $past(ctl_reg.start))
    else $error("start sent without data and start bit");
  stop_clr_a: assert property ((stop_done && !wr_ctl) |=> !ctl_reg.stop && is_idle)
    else $error("stop bit not cleared after stop");
  txdma_gate_a: assert property ((transmit_empty_flag_reg && !ctl_reg.transmit_irq_enable) |-> !tx_dma_req)
    else $error("tx dma without irq enable");
  baud_irq_a: assert property (baud_ev |=> baud_flag_reg && (irq || ctl_reg.en
    || !ctl_reg.baud_timer_irq_request))
    else $error("baud timer interrupt missing");
endmodule : twbm_master

//--- pkg/twbm_pkg.sv
// twbm_pkg: constants, register layout and types of the two-wire bus master
// assumes an 8-bit register port and a 125 MHz system clock
// Notes on behaviour
// - master only; no slave mode, no arbitration
// - bus rate never above 400 kbit/s
// - 7-bit or 10-bit addresses, unlimited byte count
// - everything on sda, most significant bit first
// - pin select switches pins to open drain
// - wait while slave holds scl low
// - change sda mid-low, sample sda mid-high
// - four sources ored onto one irq
// - per-source enables gate the transmit empty and baud timer sources; receive full and nak need only en
// - nak sets flag, waits for start/stop
// - receive full at ack, hold until read
// - transmit empty on enable and byte load, except the load of a read address byte
// - data register write clears transmit empty
// - stall before ack while transmit empty
// - disabled baud counter acts as timer interrupt
// - transmit empty flag independent of irq enable
// - separate dma requests; tx needs irq enable
// - start: sda falls; stop: sda rises; scl high
// - start instead of stop gives repeated start
// - start waits for start bit and data
// - flush discards stale transmit byte
// - ack status follows slave acknowledge
// - clear start/stop bit once condition sent
// - address-only transfer ends by clearing stop
package twbm_pkg;
  // ==========================================================
  // register port
  typedef logic [2:0] twbm_addr_type;
  typedef logic [7:0] twbm_byte_type;
  localparam twbm_addr_type TWBM_ADDR_DATA = 3'h0;
  localparam twbm_addr_type TWBM_ADDR_STAT = 3'h1;
  localparam twbm_addr_type TWBM_ADDR_CTL = 3'h2;
  localparam twbm_addr_type TWBM_ADDR_BRH = 3'h3;
  localparam twbm_addr_type TWBM_ADDR_BRL = 3'h4;
  localparam twbm_byte_type TWBM_BRG_RESET = 8'hFF;
  localparam int TWBM_RW_BIT = 0;
  // ==========================================================
  // bit timing: four baud ticks per bus bit
  localparam int TWBM_CLK_KHZ = 125000;
  localparam int TWBM_MAX_RATE_KBPS = 400;
  localparam int TWBM_QUARTERS = 4;
  localparam int TWBM_MIN_DIV = (TWBM_CLK_KHZ + TWBM_MAX_RATE_KBPS * TWBM_QUARTERS - 1)
    / (TWBM_MAX_RATE_KBPS * TWBM_QUARTERS);
  localparam logic [15:0] TWBM_MIN_RELOAD = 16'(TWBM_MIN_DIV);
  localparam logic [15:0] TWBM_CNT_ONE = 16'h0001;
  localparam logic [1:0] TWBM_PH_FIRST = 2'h0;
  localparam logic [1:0] TWBM_PH_CHANGE = 2'h1;
  localparam logic [1:0] TWBM_PH_SAMPLE = 2'h2;
  localparam logic [1:0] TWBM_PH_LAST = 2'h3;
  localparam logic [2:0] TWBM_BIT_LAST = 3'h7;
  // ==========================================================
  // control and status layouts, msb first
  typedef struct packed {
    logic en; logic start; logic stop; logic baud_timer_irq_request;
    logic transmit_irq_enable; logic nak; logic flush; logic rsvd;
  } twbm_ctl_type;
  typedef struct packed {
    logic transmit_empty_flag; logic receive_full_flag; logic ack; logic rd;
    logic baud; logic busy; logic not_acknowledged_flag; logic rsvd;
  } twbm_st_type;
  typedef struct packed {
    logic scl; logic sda;
  } twbm_pins_type;
  localparam twbm_pins_type TWBM_PINS_IDLE = 2'h3;
  // gray along idle, start, bits, ack, post, stop
  typedef enum logic [2:0] {
    TWBM_IDLE = 3'h0, TWBM_COND_START = 3'h1, TWBM_BITS = 3'h3,
    TWBM_ACK = 3'h2, TWBM_POST = 3'h6, TWBM_COND_STOP = 3'h7
  } twbm_state_type;
endpackage : twbm_pkg

//--- tb/testbench.sv
// testbench: self-checking bench of twbm_master against a behavioural slave
// assumes the register port of the package and pull-ups on both wires
`timescale 1ns/10ps
module testbench;
  import twbm_pkg::*;
  // ==========================================================
  // stimulus, wires and bookkeeping
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  twbm_addr_type reg_addr = 3'h0;
  twbm_byte_type reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_select = 1'b1; // bus function selected throughout
  logic nak_addr = 1'b0;
  logic [7:0] stretch = 8'h00;
  twbm_byte_type reg_rdata, got_byte, d, last;
  logic scl_oe_n, sda_oe_n, irq, tx_dma_req, rx_dma_req, scl_hold, sda_hold, got_tgl;
  logic scl_w, sda_w, rd_seen = 1'b0;
  logic [2:0] req_w;
  logic [15:0] e;
  logic [15:0] rd_q[$]; // expected read answers {value, mask}
  twbm_byte_type bus_q[$]; // bytes the slave must receive
  int mismatches = 0;
  int compares = 0;
  assign scl_w = scl_oe_n & !scl_hold; // wired-and, pull-up when released
  assign sda_w = sda_oe_n & !sda_hold;
  assign req_w = {irq, rx_dma_req, tx_dma_req};
  always #4 clk = !clk;
  twbm_master dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_select(pin_select),
    .scl_pin(scl_w), .scl_low(), .scl_oe_n(scl_oe_n), .sda_pin(sda_w), .sda_low(),
    .sda_oe_n(sda_oe_n), .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  twbm_slave slave_u (.clk(clk), .scl(scl_w), .sda(sda_w), .nak_addr(nak_addr),
    .stretch(stretch), .scl_hold(scl_hold), .sda_hold(sda_hold), .got_tgl(got_tgl),
    .got_byte(got_byte));
  // ==========================================================
  // checking
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) begin
      e = rd_q.pop_front();
      cmp(reg_rdata & e[7:0], e[15:8] & e[7:0]);
    end
  end
  // every byte the slave took, oldest note first; an extra byte fails
  always @(got_tgl) begin
    if ($time > 0 && bus_q.size() == 0) begin
      cmp(got_byte, ~got_byte);
    end else if ($time > 0) begin
      cmp(got_byte, bus_q.pop_front());
    end
  end
  // ==========================================================
  // register port: one-cycle strobes, a spare edge between accesses
  task automatic wr(input twbm_addr_type a, input twbm_byte_type v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input twbm_addr_type a, input twbm_byte_type x, input twbm_byte_type m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({x, m});
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 last = reg_rdata;
    @(posedge clk);
  endtask
  task automatic poll_clear(input int b);
    for (int i = 0; i < 8000 && (i == 0 || last[b] !== 1'b0); i++) begin
      rd(TWBM_ADDR_CTL, 8'h00, 8'h00);
    end
    cmp(8'(last[b]), 8'h00);
  endtask
  task automatic wait_on(input int which, input int lim);
    for (int i = 0; i < lim && req_w[which] !== 1'b1; i++) @(posedge clk);
    cmp(8'(req_w[which]), 8'h01);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h8515));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(TWBM_ADDR_CTL, 8'h00, 8'hFF);
    rd(TWBM_ADDR_BRH, TWBM_BRG_RESET, 8'hFF);
    rd(TWBM_ADDR_BRL, TWBM_BRG_RESET, 8'hFF);
    wr(3'h5, 8'h5A);
    rd(3'h5, 8'h00, 8'hFF); // unmapped place stays 0
    wr(TWBM_ADDR_BRH, 8'h00);
    wr(TWBM_ADDR_BRL, 8'h10); // clamped to the 400 kbit/s ceiling while enabled
    wr(TWBM_ADDR_CTL, 8'h80);
    rd(TWBM_ADDR_STAT, 8'h80, 8'h80);
    cmp(8'({irq, tx_dma_req}), 8'h00);
    wr(TWBM_ADDR_CTL, 8'h88);
    cmp(8'({irq, tx_dma_req}), 8'h03);
    // 10-bit write with a slow slave, a stall, then restart into a read
    stretch <= 8'h96 + 8'($urandom_range(100));
    bus_q.push_back(8'hF0);
    wr(TWBM_ADDR_DATA, 8'hF0);
    cmp(8'({irq, tx_dma_req}), 8'h00);
    wr(TWBM_ADDR_CTL, 8'hC8);
    wait_on(0, 8000);
    d = 8'($urandom());
    bus_q.push_back(d);
    wr(TWBM_ADDR_DATA, d);
    wait_on(0, 8000);
    rd(TWBM_ADDR_STAT, 8'h20, 8'h20);
    repeat (5000) @(posedge clk);
    cmp(8'(scl_oe_n), 8'h00);
    wr(TWBM_ADDR_CTL, 8'hC8);
    bus_q.push_back(8'hF1);
    wr(TWBM_ADDR_DATA, 8'hF1);
    wait_on(1, 9000);
    cmp(8'(tx_dma_req), 8'h00);
    rd(TWBM_ADDR_CTL, 8'h00, 8'h40);
    rd(TWBM_ADDR_STAT, 8'h50, 8'h50);
    repeat (400) @(posedge clk);
    wr(TWBM_ADDR_CTL, 8'h84);
    rd(TWBM_ADDR_DATA, 8'h3C, 8'hFF);
    wait_on(1, 6000);
    rd(TWBM_ADDR_DATA, 8'h83, 8'hFF);
    wait_on(2, 800);
    rd(TWBM_ADDR_STAT, 8'h02, 8'h02);
    wr(TWBM_ADDR_CTL, 8'hA0);
    poll_clear(5);
    rd(TWBM_ADDR_STAT, 8'h00, 8'h06);
    // refused address, stale byte flushed
    stretch <= 8'h00;
    nak_addr <= 1'b1;
    bus_q.push_back(8'h6E);
    wr(TWBM_ADDR_DATA, 8'h6E);
    wr(TWBM_ADDR_CTL, 8'hC0);
    repeat (600) @(posedge clk);
    wr(TWBM_ADDR_DATA, 8'h11); // never reaches the wire
    wait_on(2, 4000);
    rd(TWBM_ADDR_STAT, 8'h02, 8'h22);
    repeat (2000) @(posedge clk);
    wr(TWBM_ADDR_CTL, 8'hA2);
    poll_clear(5);
    nak_addr <= 1'b0;
    wr(TWBM_ADDR_CTL, 8'hC0);
    repeat (1000) @(posedge clk);
    cmp(8'({scl_oe_n, sda_oe_n}), 8'h03);
    // address-only probe
    bus_q.push_back(8'h30);
    wr(TWBM_ADDR_DATA, 8'h30);
    wr(TWBM_ADDR_CTL, 8'hE0);
    poll_clear(5);
    rd(TWBM_ADDR_STAT, 8'hA0, 8'hA2);
    // baud counter as a timer only while disabled
    wr(TWBM_ADDR_CTL, 8'h90);
    repeat (200) @(posedge clk);
    cmp(8'(irq), 8'h00);
    wr(TWBM_ADDR_CTL, 8'h10);
    wait_on(2, 200);
    rd(TWBM_ADDR_STAT, 8'h08, 8'h08);
    cmp(8'(bus_q.size()), 8'h00);
    conclude();
  end
  // watchdog: about 30k cycles of traffic with a generous margin
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : testbench

//--- tb/twbm_slave.sv
// twbm_slave: behavioural slave on the two-wire bus for the master bench
// assumes resolved wires with pull-ups; a hold output high pulls its line low
`timescale 1ns/10ps
module twbm_slave (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic nak_addr,
  input wire logic [7:0] stretch,
  output logic scl_hold,
  output logic sda_hold,
  output logic got_tgl,
  output logic [7:0] got_byte
);
  // ==========================================================
  // frame state
  logic active = 1'b0; // inside a frame
  logic first = 1'b0; // address byte in flight
  logic rd_mode = 1'b0; // we send data bytes
  logic [3:0] bitn = 4'h0; // bit index, 8 is the ack slot
  logic [7:0] sh = 8'h00; // incoming bits
  logic [7:0] txb = 8'h00; // outgoing byte
  logic [7:0] k = 8'h00; // bytes sent so far
  initial begin
    scl_hold = 1'b0;
    sda_hold = 1'b0;
    got_tgl = 1'b0;
    got_byte = 8'h00;
  end
  // start or restart: sda falls while scl high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      first = 1'b1;
      rd_mode = 1'b0;
      bitn = 4'h0;
    end
  end
  // stop: sda rises while scl high
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
    end
  end
  // sample at scl rise; a master nak ends our sending
  always @(posedge scl) begin
    if (active && bitn == 4'h8) begin
      if (rd_mode && !first && sda) begin
        active = 1'b0;
      end
      bitn = 4'h0;
      first = 1'b0;
    end else if (active) begin
      sh = {sh[6:0], sda};
      bitn = bitn + 4'h1;
    end
  end
  // change sda only while scl is low; released lines float to the pull-up
  always @(negedge scl) begin
    if (active && bitn == 4'h8 && (first || !rd_mode)) begin
      got_byte = sh;
      got_tgl = !got_tgl;
      rd_mode = first ? sh[0] : rd_mode;
      sda_hold = !(nak_addr && first);
    end else if (active && (bitn == 4'h8 || !rd_mode)) begin
      sda_hold = 1'b0;
    end else if (active) begin
      txb = (bitn == 4'h0) ? 8'h3C + k * 8'h47 : txb;
      k = (bitn == 4'h0) ? k + 8'h01 : k;
      sda_hold = !txb[3'h7 - bitn[2:0]];
    end
  end
  // slow slave: keep scl low for a while after each fall
  always @(negedge scl) begin
    if (active && stretch != 8'h00) begin
      scl_hold = 1'b1;
      repeat (stretch) @(posedge clk);
      scl_hold = 1'b0;
    end
  end
endmodule : twbm_slave
